// file: bps_pkg.sv
// package with timing constants and state types for the powerfail sequencer
package bps_pkg;
  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned POWERUP_US      = 50;
  localparam int unsigned POWERUP_CYC     = (POWERUP_US * (CLK_HZ / 1_000_000));
  localparam int unsigned PD_MAX_US       = 110;
  localparam int unsigned PD_MAX_CYC      = (PD_MAX_US * (CLK_HZ / 1_000_000));
  localparam int unsigned RST_MIN_NS      = 250;
  localparam int unsigned RST_MIN_CYC     = (RST_MIN_NS * 40 + 999) / 1000;
  localparam int unsigned COIL_STOP_CYC   = 16;
  localparam int unsigned CNT_W           = 13;
  localparam logic [1:0]  PHASE_RESET     = 2'h0;
  localparam logic        RESET_OUT_RST   = 1'b1;

  typedef enum logic [2:0] {
    BPS_OFF,
    BPS_POWERUP,
    BPS_RUN,
    BPS_COIL_STOP,
    BPS_HALTED
  } bps_state_t;
endpackage

// file: bps_sync_if.sv
// interface carrying synchronised pin levels and their edges
`timescale 1ns/1ps
interface bps_sync_if;
  logic fail_n;
  logic fail_rise;
  logic fail_fall;
  logic ext_rst_n;
  logic ext_rst_fall;
  modport src (output fail_n, fail_rise, fail_fall, ext_rst_n, ext_rst_fall);
  modport dst (input fail_n, fail_rise, fail_fall, ext_rst_n, ext_rst_fall);
endinterface

// file: bps_pin_sync.sv
// two-stage synchronisers and edge detectors for the supply and reset pins
`timescale 1ns/1ps
module bps_pin_sync
  import bps_pkg::*;
(
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic arst_n,
  // raw pins
  input  wire logic supply_fail_n,
  input  wire logic ext_reset_n,
  // synchronised view
  bps_sync_if.src   sync
);
  logic [1:0] fail_sr;
  logic [1:0] rst_sr;
  logic       fail_d;
  logic       rst_d;

  // supply pin idles low at reset so a first rising supply edge is always seen; reset pin idles high
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      fail_sr <= 2'h0;
      rst_sr  <= 2'h3;
      fail_d  <= 1'b0;
      rst_d   <= 1'b1;
    end else begin
      fail_sr <= {fail_sr[0], supply_fail_n};
      rst_sr  <= {rst_sr[0], ext_reset_n};
      fail_d  <= fail_sr[1];
      rst_d   <= rst_sr[1];
    end
  end

  assign sync.fail_n       = fail_sr[1];
  assign sync.fail_rise    = fail_sr[1] & ~fail_d;
  assign sync.fail_fall    = ~fail_sr[1] & fail_d;
  assign sync.ext_rst_n    = rst_sr[1];
  assign sync.ext_rst_fall = ~rst_sr[1] & rst_d;
endmodule

// file: bps_sequencer.sv
// power-up and power-down sequencer of the bubble controller
`timescale 1ns/1ps
// Overview of operation
// - the supply monitor holds supply_fail_n low while either supply is under about 92 percent.
// - supply_fail_n is not latched and follows every threshold crossing.
// - supply_fail_n is held low 2 msec past good supplies; its rising edge starts power-up.
// - support reset stays active through the 50 us power-up and drops when it ends.
// - a falling edge on supply_fail_n or on the external reset starts power-down, but only in BPS_RUN.
// - with coils running, coil drive stops at the proper phase in the same cycle that support reset asserts.
// - power-down lasts longer when the coils are rotating at its start.
// - if supply_fail_n returns high during a power-down that it started, that power-down is abandoned at once.
// - the external reset is sampled and latched and must be low for at least 250 ns.
// - an asserted external reset stops activity and holds support reset while it stays low.
module bps_sequencer
  import bps_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  // supply monitor and system reset pins
  input  wire logic       supply_fail_n,
  input  wire logic       ext_reset_n,
  // host command side
  input  wire logic       abort_cmd,
  input  wire logic       coil_run_req,
  // coil drive
  output logic            coil_drive_en,
  output logic [1:0]      coil_phase,
  // support-circuit reset, open drain
  output logic            support_reset_out,
  output logic            support_reset_oe,
  // status
  output logic            powerup_busy,
  output logic            powerdown_busy,
  output logic            powerdown_abandoned
);
  bps_sync_if sync ();

  bps_pin_sync u_sync (
    .sys_clk       (sys_clk),
    .arst_n        (arst_n),
    .supply_fail_n (supply_fail_n),
    .ext_reset_n   (ext_reset_n),
    .sync          (sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  bps_state_t       state;
  bps_state_t       next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic             sup_rst;
  logic             next_sup_rst;
  logic             coil_en;
  logic             next_coil_en;
  logic [1:0]       phase;
  logic             rst_latched;
  logic             pd_by_fail;
  logic             next_pd_by_fail;
  logic             abandoned;

  // the pin is latched while low; release needs the synchronised level high
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_latched <= 1'b0;
    end else begin
      rst_latched <= ~sync.ext_rst_n;
    end
  end

  wire pd_trigger   = sync.fail_fall | sync.ext_rst_fall;
  wire phase_home   = (phase == PHASE_RESET);
  wire cnt_done     = (cnt == '0);
  // a supply-edge power-down is cut short by the supply returning
  wire pd_abandon   = pd_by_fail & sync.fail_rise;
  wire [CNT_W-1:0] powerup_load = CNT_W'(POWERUP_CYC - 1);
  wire [CNT_W-1:0] stop_load    = CNT_W'(COIL_STOP_CYC - 1);

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_state      = state;
    next_cnt        = cnt;
    next_sup_rst    = sup_rst;
    next_coil_en    = coil_en;
    next_pd_by_fail = pd_by_fail;
    unique case (state)
      BPS_OFF: begin
        next_sup_rst = 1'b1;
        next_coil_en = 1'b0;
        if (sync.fail_rise) begin
          next_state = BPS_POWERUP;
          next_cnt   = powerup_load;
        end
      end
      BPS_POWERUP: begin
        next_sup_rst = 1'b1;
        if (cnt_done) begin
          next_state   = BPS_RUN;
          // an active external reset keeps support reset asserted
          next_sup_rst = rst_latched;
        end else begin
          next_cnt = cnt - CNT_W'(1);
        end
      end
      BPS_RUN: begin
        next_coil_en = coil_run_req;
        if (abort_cmd && !rst_latched) begin
          next_sup_rst = 1'b0;
        end
        if (pd_trigger) begin
          next_pd_by_fail = sync.fail_fall;
          next_coil_en    = coil_en;
          if (coil_en) begin
            next_state = BPS_COIL_STOP;
            next_cnt   = stop_load;
          end else begin
            next_state   = BPS_HALTED;
            next_sup_rst = 1'b1;
          end
        end
      end
      BPS_COIL_STOP: begin
        // coils keep stepping until the home phase, then drive stops
        if (pd_abandon) begin
          // restart halts the coils where they stand; the phase may be lost
          next_state   = BPS_POWERUP;
          next_cnt     = powerup_load;
          next_coil_en = 1'b0;
          next_sup_rst = 1'b1;
        end else if (phase_home || cnt_done) begin
          next_coil_en = 1'b0;
          next_sup_rst = 1'b1;
          next_state   = BPS_HALTED;
        end else begin
          next_cnt = cnt - CNT_W'(1);
        end
      end
      BPS_HALTED: begin
        next_coil_en = 1'b0;
        next_sup_rst = 1'b1;
        if (pd_abandon) begin
          next_state = BPS_POWERUP;
          next_cnt   = powerup_load;
        end else if (!pd_by_fail && !rst_latched && sync.fail_n) begin
          // reset released: controller runs again, abort still needed
          next_state = BPS_RUN;
        end
      end
    endcase
    // external reset held low during power-up keeps support reset asserted
    if (rst_latched && (state == BPS_POWERUP)) begin
      next_sup_rst = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state      <= BPS_OFF;
      cnt        <= '0;
      sup_rst    <= RESET_OUT_RST;
      coil_en    <= 1'b0;
      pd_by_fail <= 1'b0;
    end else begin
      state      <= next_state;
      cnt        <= next_cnt;
      sup_rst    <= next_sup_rst;
      coil_en    <= next_coil_en;
      pd_by_fail <= next_pd_by_fail;
    end
  end

  // phase advances while coils run; stop lands on the home phase
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      phase     <= PHASE_RESET;
      abandoned <= 1'b0;
    end else begin
      if (coil_en && !(state == BPS_COIL_STOP && phase_home)) begin
        phase <= phase + 2'h1;
      end
      if (pd_abandon && (state == BPS_COIL_STOP || state == BPS_HALTED)) begin
        abandoned <= 1'b1;
      end else if (abort_cmd) begin
        abandoned <= 1'b0;
      end
    end
  end

  assign coil_drive_en       = coil_en;
  assign coil_phase          = phase;
  assign support_reset_out   = 1'b0;
  assign support_reset_oe    = sup_rst;
  assign powerup_busy        = (state == BPS_POWERUP) | (state == BPS_OFF);
  assign powerdown_busy      = (state == BPS_COIL_STOP);
  assign powerdown_abandoned = abandoned;
endmodule

// file: bps_sva.sv
// assertions for the powerfail sequencer
`timescale 1ns/1ps
module bps_sva
  import bps_pkg::*;
(
  // clock and reset
  input wire logic       sys_clk, arst_n,
  // pins and host side
  input wire logic       supply_fail_n, ext_reset_n, abort_cmd, coil_run_req,
  // outputs
  input wire logic       coil_drive_en, support_reset_out, support_reset_oe,
  input wire logic [1:0] coil_phase,
  input wire logic       powerup_busy, powerdown_busy, powerdown_abandoned
);
  localparam int STOP_MAX = 17;
  logic [5:0] low_cnt, ok_cnt;
  // saturating counters: long holds exceed what a repetition may unroll
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      low_cnt <= 6'h00;
      ok_cnt  <= 6'h00;
    end else begin
      low_cnt <= ext_reset_n ? 6'h00 : low_cnt + {5'h00, ~&low_cnt};
      ok_cnt  <= (ext_reset_n && supply_fail_n) ? ok_cnt + {5'h00, ~&ok_cnt} : 6'h00;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  sequence s_stop_done;
    !coil_drive_en && coil_phase == PHASE_RESET && support_reset_oe;
  endsequence
  a_pu_holds_rst: assert property (powerup_busy |-> support_reset_oe)
    else $error("support reset dropped in power-up");
  a_od_data_low: assert property (support_reset_out == 1'b0)
    else $error("open drain data high");
  a_stop_at_home: assert property ($fell(powerdown_busy) && !powerup_busy |-> s_stop_done)
    else $error("coil stop not at home phase");
  a_rst_coils_off: assert property ($rose(support_reset_oe) |-> !coil_drive_en)
    else $error("support reset with coils driven");
  a_stop_bounded: assert property ($rose(powerdown_busy) |-> ##[1:STOP_MAX] !powerdown_busy)
    else $error("coil stop too long");
  a_ext_holds_rst: assert property (low_cnt > 6'd24 |-> support_reset_oe)
    else $error("support reset free under ext reset");
  a_abort_release: assert property (abort_cmd && ok_cnt > 6'd8 && !powerup_busy && !powerdown_busy
    |=> !support_reset_oe)
    else $error("abort did not release");
  a_abandon_flag: assert property ($rose(powerup_busy) && $past(powerdown_busy)
    |-> ##[0:1] powerdown_abandoned)
    else $error("abandon not flagged");
  a_idle_direct: assert property (($fell(ext_reset_n) || $fell(supply_fail_n)) && !coil_drive_en
    && !coil_run_req |-> ##[1:5] support_reset_oe)
    else $error("idle power-down slow");
endmodule
bind bps_sequencer bps_sva u_bps_sva (.sys_clk(sys_clk), .arst_n(arst_n),
  .supply_fail_n(supply_fail_n), .ext_reset_n(ext_reset_n), .abort_cmd(abort_cmd),
  .coil_run_req(coil_run_req), .coil_drive_en(coil_drive_en), .coil_phase(coil_phase),
  .support_reset_out(support_reset_out), .support_reset_oe(support_reset_oe),
  .powerup_busy(powerup_busy), .powerdown_busy(powerdown_busy),
  .powerdown_abandoned(powerdown_abandoned));

// file: bps_supply_mon.sv
// supply monitor model driving the supply fail pin
`timescale 1ns/1ps
module bps_supply_mon #(
  parameter int HOLD_CYC = 40
) (
  // clock
  input  wire logic sys_clk,
  // rail state and fast return
  input  wire logic rails_ok,
  input  wire logic fast_ret,
  // pin
  output logic      supply_fail_n
);
  int hold_cnt = 0;
  // not latched: any dip restarts the hold delay
  always @(posedge sys_clk)
    hold_cnt <= !rails_ok ? 0 : (hold_cnt < HOLD_CYC) ? hold_cnt + 1 : hold_cnt;
  // fast_ret skips the hold, used only to force an early return
  assign supply_fail_n = rails_ok && (fast_ret || hold_cnt == HOLD_CYC);
endmodule

// file: tb_top.sv
// self-checking bench for the powerfail sequencer
`timescale 1ns/1ps
module tb_top;
  import bps_pkg::*;
  logic sys_clk = 1'b0, arst_n = 1'b0, rails_ok = 1'b0, fast_ret = 1'b0;
  logic ext_reset_n = 1'b1, abort_cmd = 1'b0, coil_run_req = 1'b0;
  logic supply_fail_n, coil_drive_en, support_reset_out, support_reset_oe;
  logic powerup_busy, powerdown_busy, powerdown_abandoned;
  logic [1:0] coil_phase;
  logic [15:0] exp_q[$];
  logic [15:0] obs;
  event seen;
  int mismatches = 0, samples_checked = 0, cyc = 0, seed = 32'hddc8, n;
  always #12.5 sys_clk = ~sys_clk;
  bps_supply_mon u_bps_supply_mon (.sys_clk(sys_clk), .rails_ok(rails_ok),
    .fast_ret(fast_ret), .supply_fail_n(supply_fail_n));
  bps_sequencer u_bps_sequencer (.sys_clk(sys_clk), .arst_n(arst_n),
    .supply_fail_n(supply_fail_n), .ext_reset_n(ext_reset_n), .abort_cmd(abort_cmd),
    .coil_run_req(coil_run_req), .coil_drive_en(coil_drive_en), .coil_phase(coil_phase),
    .support_reset_out(support_reset_out), .support_reset_oe(support_reset_oe),
    .powerup_busy(powerup_busy), .powerdown_busy(powerdown_busy),
    .powerdown_abandoned(powerdown_abandoned));
  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic check(logic [15:0] got, logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // driver notes the expectation; the watcher pairs it with the seen value
  task automatic note(logic [15:0] got, logic [15:0] exp);
    exp_q.push_back(exp);
    obs = got;
    -> seen;
    #1;
  endtask
  always @(seen) check(obs, exp_q.pop_front());
  task automatic wait_for(ref logic s, input logic v);
    n = 0;
    while (s !== v && n < 3000) begin
      @(negedge sys_clk);
      n++;
    end
    if (s !== v) mismatches++;
  endtask
  task automatic abort();
    @(posedge sys_clk) abort_cmd <= 1'b1;
    @(posedge sys_clk) abort_cmd <= 1'b0;
    @(negedge sys_clk);
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      report_and_stop();
    end
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(negedge sys_clk);
    note({12'h0, support_reset_out, coil_drive_en, coil_phase}, 16'h0);
    @(posedge sys_clk) rails_ok <= 1'b1;
    wait_for(supply_fail_n, 1'b1);
    wait_for(powerup_busy, 1'b0);
    note({15'h0, n >= POWERUP_CYC && n <= POWERUP_CYC + 6}, 16'h1);
    note({15'h0, support_reset_oe}, 16'h0);
    abort();
    note({15'h0, support_reset_oe}, 16'h0);
    // coils running, power-down through the ext reset pin
    @(posedge sys_clk) coil_run_req <= 1'b1;
    repeat (5 + $unsigned($random(seed)) % 40) @(posedge sys_clk);
    ext_reset_n <= 1'b0;
    wait_for(powerdown_busy, 1'b1);
    note({15'h0, support_reset_oe}, 16'h0);
    wait_for(powerdown_busy, 1'b0);
    note({12'h0, coil_drive_en, support_reset_oe, coil_phase}, 16'h4);
    abort();
    repeat (30) @(negedge sys_clk);
    note({15'h0, support_reset_oe}, 16'h1);
    @(posedge sys_clk) coil_run_req <= 1'b0;
    ext_reset_n <= 1'b1;
    repeat (12) @(negedge sys_clk);
    note({15'h0, support_reset_oe}, 16'h1);
    abort();
    note({15'h0, support_reset_oe}, 16'h0);
    // coils idle, power-down through the supply pin
    @(posedge sys_clk) rails_ok <= 1'b0;
    repeat (6) @(negedge sys_clk);
    note({15'h0, support_reset_oe}, 16'h1);
    @(posedge sys_clk) rails_ok <= 1'b1;
    repeat (60) @(negedge sys_clk);
    wait_for(powerup_busy, 1'b0);
    abort();
    // supply glitch while coils run abandons the power-down
    @(posedge sys_clk) coil_run_req <= 1'b1;
    repeat (5 + $unsigned($random(seed)) % 20) @(posedge sys_clk);
    fast_ret <= 1'b1;
    rails_ok <= 1'b0;
    @(posedge sys_clk) rails_ok <= 1'b1;
    repeat (8) @(negedge sys_clk);
    note({14'h0, powerdown_abandoned, powerup_busy}, 16'h3);
    wait_for(powerup_busy, 1'b0);
    abort();
    note({15'h0, powerdown_abandoned}, 16'h0);
    report_and_stop();
  end
endmodule
